/* lrd_ctrl.sv */
/*
 Ladder reference converter control top: holds both control registers,
 drives ladder switches and output pin override.
 Assumes a host writes registers with one-cycle write strobes on mclk;
 pin_in arrives asynchronously and is synchronised here.
*/
`timescale 1ns/1ps
`include "lrd_consts.svh"
module lrd_ctrl
	import lrd_pkg::*;
(
	input wire logic mclk, // 10 MHz clock
	input wire logic reset, // Sync reset, active high
	input wire logic ctrl_write, // Write strobe, first register
	input wire logic level_write, // Write strobe, level register
	input wire logic [7:0] write_data, // Write data
	input wire logic wake, // Wake from sleep pulse
	input wire logic pin_in, // Raw pin input level
	output logic [7:0] converter_control_first, // Readback first register
	output logic [7:0] converter_level_register, // Readback level register
	output logic [31:0] tap_select, // Ladder tap one-hot
	output logic [2:0] high_connect, // High source switches
	output logic [1:0] low_connect, // Low source switches
	output logic clamp_high, // Output clamped high
	output logic clamp_low, // Output clamped low
	output logic reference_output_pin_route, // Analog onto pin
	output logic pin_out_enable_n, // Digital buffer enable, low drives
	output logic pin_read // Digital read value
);
	logic converter_enable;
	logic idle_rail_select;
	logic pin_drive_enable;
	logic [1:0] high_source_select;
	logic low_source_select;
	logic [4:0] level_code;
	logic pin_sync1;
	logic pin_sync2;
	logic [31:0] next_tap;
	logic [2:0] next_high;
	logic [1:0] next_low;
	logic next_clamp_high;
	logic next_clamp_low;

	// First control register; wake has no effect on it
	always_ff @(posedge mclk) begin
		if (reset) begin
			converter_enable <= 1'b0;
			idle_rail_select <= 1'b0;
			pin_drive_enable <= 1'b0;
			high_source_select <= 2'h0;
			low_source_select <= 1'b0;
		end else if (ctrl_write) begin
			converter_enable <= write_data[`LRD_BIT_EN];
			idle_rail_select <= write_data[`LRD_BIT_IDLE];
			pin_drive_enable <= write_data[`LRD_BIT_OE];
			high_source_select <= write_data[`LRD_BIT_HSEL_HI:`LRD_BIT_HSEL_LO];
			low_source_select <= write_data[`LRD_BIT_LSEL];
		end
	end

	// Level register, low five bits only
	always_ff @(posedge mclk) begin
		if (reset)
			level_code <= `LRD_CODE_ZERO;
		else if (level_write)
			level_code <= write_data[`LRD_CODE_W-1:0];
	end

	// Readback with unused bits zero; registered outputs
	always_ff @(posedge mclk) begin
		if (reset) begin
			converter_control_first <= `LRD_CTRL_RST;
			converter_level_register <= `LRD_LEVEL_RST;
		end else begin
			converter_control_first <= {converter_enable, idle_rail_select,
				pin_drive_enable, 1'b0, high_source_select, 1'b0,
				low_source_select};
			converter_level_register <= {3'h0, level_code};
		end
	end

	// Two-stage sync on raw pin before anything reads it
	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_sync1 <= 1'b0;
			pin_sync2 <= 1'b0;
		end else begin
			pin_sync1 <= pin_in;
			pin_sync2 <= pin_sync1;
		end
	end

	// Pin override: analog routed, digital buffer off, reads zero
	always_ff @(posedge mclk) begin
		if (reset) begin
			reference_output_pin_route <= 1'b0;
			pin_out_enable_n <= 1'b1;
			pin_read <= 1'b0;
		end else begin
			reference_output_pin_route <= pin_drive_enable;
			pin_out_enable_n <= 1'b1;
			pin_read <= pin_drive_enable ? 1'b0 : pin_sync2;
		end
	end

	lrd_ladder_map u_map (
		.enable(converter_enable),
		.idle_rail_select(idle_rail_select),
		.high_source_select(high_source_select),
		.low_source_select(low_source_select),
		.level_code(level_code),
		.tap_onehot(next_tap),
		.high_connect(next_high),
		.low_connect(next_low),
		.clamp_high(next_clamp_high),
		.clamp_low(next_clamp_low)
	);

	// Ladder outputs follow fields with one register stage
	always_ff @(posedge mclk) begin
		if (reset) begin
			tap_select <= 32'h0;
			high_connect <= 3'h0;
			low_connect <= 2'h0;
			clamp_high <= 1'b0;
			clamp_low <= 1'b0;
		end else begin
			tap_select <= next_tap;
			high_connect <= next_high;
			low_connect <= next_low;
			clamp_high <= next_clamp_high;
			clamp_low <= next_clamp_low;
		end
	end

	property p_disabled_no_tap;
		@(posedge mclk) disable iff (reset)
		!converter_enable |=> tap_select == 32'h0;
	endproperty
	a_disabled_no_tap: assert property (p_disabled_no_tap) else $error("tap while disabled");

	property p_tap_matches_code;
		@(posedge mclk) disable iff (reset)
		converter_enable |=> tap_select == (32'h1 << $past(level_code));
	endproperty
	a_tap_matches_code: assert property (p_tap_matches_code) else $error("wrong tap");

	property p_clamp_high;
		@(posedge mclk) disable iff (reset)
		(!converter_enable && idle_rail_select && level_code == 5'h1f) |=> clamp_high;
	endproperty
	a_clamp_high: assert property (p_clamp_high) else $error("no high clamp");

	property p_clamp_low;
		@(posedge mclk) disable iff (reset)
		(!converter_enable && !idle_rail_select && level_code == 5'h00) |=> clamp_low;
	endproperty
	a_clamp_low: assert property (p_clamp_low) else $error("no low clamp");

	property p_one_end;
		@(posedge mclk) disable iff (reset)
		(!converter_enable && idle_rail_select) |=> low_connect == 2'h0;
	endproperty
	a_one_end: assert property (p_one_end) else $error("low end powered");

	property p_route;
		@(posedge mclk) disable iff (reset)
		pin_drive_enable |=> reference_output_pin_route && pin_out_enable_n;
	endproperty
	a_route: assert property (p_route) else $error("pin not routed");

	property p_read_zero;
		@(posedge mclk) disable iff (reset)
		pin_drive_enable |=> !pin_read;
	endproperty
	a_read_zero: assert property (p_read_zero) else $error("pin read not zero");

	property p_wake_keeps;
		@(posedge mclk) disable iff (reset)
		(wake && !ctrl_write) |=> $stable(converter_enable) && $stable(high_source_select);
	endproperty
	a_wake_keeps: assert property (p_wake_keeps) else $error("wake changed control");

	property p_reset_clears;
		@(posedge mclk) reset |=> level_code == 5'h00 && !reference_output_pin_route;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset incomplete");

	property p_supply_decode;
		@(posedge mclk) disable iff (reset)
		(converter_enable && high_source_select == 2'h0) |=> high_connect == 3'h1;
	endproperty
	a_supply_decode: assert property (p_supply_decode) else $error("bad high decode");

	// Reserved high code must never close a source switch
	property p_high_reserved;
		@(posedge mclk) disable iff (reset)
		high_source_select == `LRD_HSEL_RSVD |=> high_connect == 3'h0;
	endproperty
	a_high_reserved: assert property (p_high_reserved) else $error("reserved code connected");

	// Low side picks the reference pin when its select is set
	property p_low_decode;
		@(posedge mclk) disable iff (reset)
		(converter_enable && low_source_select) |=> low_connect == 2'h2;
	endproperty
	a_low_decode: assert property (p_low_decode) else $error("bad low decode");

	// Idle rail cleared leaves the high end unpowered
	property p_high_end_off;
		@(posedge mclk) disable iff (reset)
		(!converter_enable && !idle_rail_select) |=> high_connect == 3'h0;
	endproperty
	a_high_end_off: assert property (p_high_end_off) else $error("high end powered");

	// Level write lands in the low five bits only
	property p_level_load;
		@(posedge mclk) disable iff (reset)
		level_write |=> {3'h0, level_code} == ($past(write_data) & 8'h1f);
	endproperty
	a_level_load: assert property (p_level_load) else $error("level code not loaded");

	// Unimplemented readback bits never show a one
	property p_unused_zero;
		@(posedge mclk) disable iff (reset)
		converter_control_first[4] == 1'b0 && converter_control_first[1] == 1'b0 &&
			converter_level_register[7:5] == 3'h0;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

	// Reset leaves converter off and pin released
	property p_reset_fields;
		@(posedge mclk) reset |=> !converter_enable && !pin_drive_enable;
	endproperty
	a_reset_fields: assert property (p_reset_fields) else $error("reset left converter on");
endmodule

/* lrd_consts.svh */
/*
 Constants for the ladder reference converter control: field widths,
 source select codes, reset values. Assumes inclusion by bare name.
*/
// Function
// - Converter active only while enable is set
// - Five-bit level code gives 32 levels
// - Enabled output is low plus span times code/32
// - Disabled, idle rail set, ones: clamp high
// - Disabled, idle rail clear, zeros: clamp low
// - Idle rail select disconnects one ladder end
// - Pin drive enable routes output, overrides pin
// - Pin read returns zero while carrying voltage
// - Wake from sleep keeps first control register
// - Reset disables, frees pin, clears level code
// - High source select decodes supply/pin/buffer
// - Low source select picks pin or ground
// - All fields reset zero, unused bits zero
`ifndef LRD_CONSTS_SVH
`define LRD_CONSTS_SVH
`define LRD_CODE_W 5
`define LRD_LEVELS 32
`define LRD_CODE_ONES 5'h1f
`define LRD_CODE_ZERO 5'h00
`define LRD_HSEL_SUPPLY 2'h0
`define LRD_HSEL_PIN 2'h1
`define LRD_HSEL_BUFFER 2'h2
`define LRD_HSEL_RSVD 2'h3
`define LRD_CTRL_RST 8'h00
`define LRD_LEVEL_RST 8'h00
`define LRD_BIT_EN 7
`define LRD_BIT_IDLE 6
`define LRD_BIT_OE 5
`define LRD_BIT_HSEL_HI 3
`define LRD_BIT_HSEL_LO 2
`define LRD_BIT_LSEL 0
`endif

/* lrd_pkg.sv */
/*
 Types for the ladder reference converter control.
 Assumes lrd_consts.svh is available on the include path.
*/
package lrd_pkg;
	typedef enum logic [1:0] {
		lrd_hsrc_supply_type_v = 2'h0,
		lrd_hsrc_pin_type_v = 2'h1,
		lrd_hsrc_buffer_type_v = 2'h2,
		lrd_hsrc_none_type_v = 2'h3
	} lrd_hsrc_type;
endpackage

/* lrd_ladder_map.sv */
/*
 Combinational ladder tap and source connection map.
 Assumes registered control fields from the top module.
*/
`timescale 1ns/1ps
`include "lrd_consts.svh"
module lrd_ladder_map
	import lrd_pkg::*;
(
	input wire logic enable, // Converter enable
	input wire logic idle_rail_select, // Idle rail choice
	input wire logic [1:0] high_source_select, // High source code
	input wire logic low_source_select, // Low source code
	input wire logic [4:0] level_code, // Level code
	output logic [31:0] tap_onehot, // Selected ladder tap
	output logic [2:0] high_connect, // Supply, pin, buffer switches
	output logic [1:0] low_connect, // Ground, pin switches
	output logic clamp_high, // Output tied to high end
	output logic clamp_low // Output tied to low end
);
	logic high_end_on;
	logic low_end_on;

	// Idle mode powers only one ladder end
	always_comb begin
		high_end_on = enable | idle_rail_select;
		low_end_on = enable | ~idle_rail_select;
		clamp_high = ~enable & idle_rail_select & (level_code == `LRD_CODE_ONES);
		clamp_low = ~enable & ~idle_rail_select & (level_code == `LRD_CODE_ZERO);
	end

	// Tap k yields low + span*k/32; taps driven only when enabled
	always_comb begin
		tap_onehot = 32'h0;
		if (enable)
			tap_onehot[level_code] = 1'b1;
	end

	// Reserved high code connects nothing, avoiding a short
	always_comb begin
		high_connect = 3'h0;
		if (high_end_on) begin
			unique case (lrd_hsrc_type'(high_source_select))
				lrd_hsrc_supply_type_v: high_connect = 3'h1;
				lrd_hsrc_pin_type_v: high_connect = 3'h2;
				lrd_hsrc_buffer_type_v: high_connect = 3'h4;
				lrd_hsrc_none_type_v: high_connect = 3'h0;
			endcase
		end
		low_connect = 2'h0;
		if (low_end_on)
			low_connect = low_source_select ? 2'h2 : 2'h1;
	end
endmodule

/* lrd_pin_model.sv */
/*
 Model of the reference output pin as the outside world sees it.
 Assumes the control block reports when the analog level is routed out.
*/
`timescale 1ns/1ps
module lrd_pin_model (
	input wire logic mclk, // Bench clock
	input wire logic route, // Analog level on pin
	input wire logic level, // Digital level applied by bench
	output logic pin_in // Level seen by input buffer
);
	logic toggle = 1'b0;
	// Analog on pin gives no usable digital level, so keep it moving
	always @(posedge mclk) begin
		toggle <= !toggle;
	end
	assign pin_in = route ? toggle : level;
endmodule

/* tb_lrd_ctrl.sv */
/*
 Self-checking bench for the converter control top.
 Assumes two-edge write latency and the reset levels of the control top.
*/
`timescale 1ns/1ps
module tb_lrd_ctrl;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic ctrl_write = 1'b0;
	logic level_write = 1'b0;
	logic [7:0] write_data = 8'h00;
	logic wake = 1'b0;
	logic pin_lvl = 1'b1;
	logic pin_in;
	logic [7:0] converter_control_first, converter_level_register;
	logic [31:0] tap_select;
	logic [2:0] high_connect;
	logic [1:0] low_connect;
	logic clamp_high, clamp_low, reference_output_pin_route, pin_out_enable_n, pin_read;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	// Control words beside level words; outputs follow from expv
	logic [7:0] rows [8][2] = '{'{8'h80, 8'h00}, '{8'h84, 8'h1f}, '{8'h89, 8'h10},
		'{8'h8c, 8'h03}, '{8'h44, 8'h1f}, '{8'h01, 8'h00}, '{8'h20, 8'h07}, '{8'hff, 8'hff}};
	lrd_ctrl dut (.mclk(mclk), .reset(reset), .ctrl_write(ctrl_write),
		.level_write(level_write), .write_data(write_data), .wake(wake), .pin_in(pin_in),
		.converter_control_first(converter_control_first),
		.converter_level_register(converter_level_register), .tap_select(tap_select),
		.high_connect(high_connect), .low_connect(low_connect), .clamp_high(clamp_high),
		.clamp_low(clamp_low), .reference_output_pin_route(reference_output_pin_route),
		.pin_out_enable_n(pin_out_enable_n), .pin_read(pin_read));
	lrd_pin_model pin (.mclk(mclk), .route(reference_output_pin_route), .level(pin_lvl),
		.pin_in(pin_in));
	always #50 mclk = !mclk;
	// Expected port picture for one pair of register values
	function automatic logic [55:0] expv(input logic [7:0] c, input logic [7:0] l);
		logic [2:0] hc;
		logic [1:0] lc;
		hc = (c[3:2] == 2'h3) ? 3'h0 : 3'h1 << c[3:2];
		if (!c[7] && !c[6]) hc = 3'h0;
		lc = c[0] ? 2'h2 : 2'h1;
		if (!c[7] && c[6]) lc = 2'h0;
		return {c[5], c & 8'hed, 3'h0, l[4:0], c[7] ? 32'h1 << l[4:0] : 32'h0, hc, lc,
			!c[7] && c[6] && l[4:0] == 5'h1f, !c[7] && !c[6] && l[4:0] == 5'h00};
	endfunction
	function automatic logic [55:0] got();
		return {reference_output_pin_route, converter_control_first, converter_level_register,
			tap_select, high_connect, low_connect, clamp_high, clamp_low};
	endfunction
	// One-cycle write strobe, released on the edge that takes it
	task wr(input logic c, input logic [7:0] d);
		@(posedge mclk);
		ctrl_write <= c;
		level_write <= !c;
		write_data <= d;
		@(posedge mclk);
		ctrl_write <= 1'b0;
		level_write <= 1'b0;
	endtask
	task settle();
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask
	task chk(input logic [55:0] g, input logic [55:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task final_report();
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard well above the hundred or so cycles the run needs
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		settle();
		chk(got(), expv(8'h00, 8'h00));
		for (int i = 0; i < 8; i++) begin
			wr(1'b1, rows[i][0]);
			wr(1'b0, rows[i][1]);
			settle();
			chk(got(), expv(rows[i][0], rows[i][1]));
			chk({pin_out_enable_n, pin_read}, {1'b1, !rows[i][0][5]});
		end
		// Mid-run reset after every field was set
		@(posedge mclk);
		reset <= 1'b1;
		@(posedge mclk);
		reset <= 1'b0;
		@(negedge mclk);
		chk(got(), 56'h0);
		chk({pin_out_enable_n, pin_read}, 2'h2);
		// Cleared fields clamp the output low once reset is gone
		settle();
		chk(got(), expv(8'h00, 8'h00));
		// Wake must leave the settings alone
		wr(1'b1, 8'hc5);
		wr(1'b0, 8'h0a);
		@(posedge mclk);
		wake <= 1'b1;
		@(posedge mclk);
		wake <= 1'b0;
		settle();
		chk(got(), expv(8'hc5, 8'h0a));
		chk(pin_read, 1'b1);
		// Reference switched off before sleep, as software should
		wr(1'b1, 8'h44);
		@(posedge mclk);
		wake <= 1'b1;
		@(posedge mclk);
		wake <= 1'b0;
		settle();
		chk(got(), expv(8'h44, 8'h0a));
		final_report();
	end
endmodule
